// file: bench/bridge_window_config_regs_tb_top.sv
// self-checking bench for the bridge window registers
module bridge_window_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] ofs; logic [3:0] be; logic [31:0] wd; logic [31:0] ex;} bwcr_row_t;
    logic clk = 1'b0; // 25 MHz
    logic rst_n = 1'b0; // active low
    logic ce = 1'b1; // enabled except during the clock enable test
    logic [3:0] io_base_low = 4'h0; // io bottom bits 15:12
    logic [3:0] io_limit_low = 4'h0; // io top bits 15:12
    logic [63:0] fwd_addr = 64'h0; // address to classify
    logic cfg_wr, cfg_rd, mem_hit, io_hit;
    logic [7:0] cfg_offset;
    logic [3:0] cfg_byte_en;
    logic [31:0] cfg_wdata, cfg_rdata, rdv;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    // write rows then read back; unmapped 38h must read zero
    bwcr_row_t rows [6] = '{
        '{8'h24, 4'hF, 32'hFFFF_FFFF, 32'hFFF1_FFF1}, '{8'h28, 4'hF, 32'h1234_5678, 32'h1234_5678},
        '{8'h2C, 4'h3, 32'hAAAA_BBBB, 32'h0000_BBBB}, '{8'h30, 4'hC, 32'hDEAD_BEEF, 32'hDEAD_0000},
        '{8'h34, 4'hF, 32'hFFFF_FFFF, 32'h0000_00DC}, '{8'h38, 4'hF, 32'hFFFF_FFFF, 32'h0}};
    always #20 clk = ~clk;
    bwcr_regs i_bwcr_regs (.clk(clk), .rst_n(rst_n), .ce(ce), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_offset(cfg_offset), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .io_base_low(io_base_low), .io_limit_low(io_limit_low),
        .fwd_addr(fwd_addr), .mem_hit(mem_hit), .io_hit(io_hit));
    bwcr_host i_bwcr_host (.clk(clk), .cfg_rdata(cfg_rdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_offset(cfg_offset), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata));
    // compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    // present an address, look at the hits one cycle later
    task automatic probe(input logic [63:0] a, input logic [1:0] exp);
        @(posedge clk);
        fwd_addr <= a;
        @(posedge clk);
        @(negedge clk);
        check({mem_hit, io_hit}, exp);
    endtask : probe
    // closing report, the only exit
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // hang guard, the whole run needs well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[k]) begin
            i_bwcr_host.wr(rows[k].ofs, rows[k].be, rows[k].wd);
            i_bwcr_host.rd(rows[k].ofs, rdv);
            check(rdv, rows[k].ex);
        end
        $display("register table test done");
        // back-to-back write and read, read must see the new value
        i_bwcr_host.wr_rd(8'h2C, 4'hF, 32'h0BAD_F00D, rdv);
        check(rdv, 32'h0BAD_F00D);
        i_bwcr_host.wr_rd(8'h30, 4'h3, 32'h1111_2222, rdv);
        check(rdv, 32'hDEAD_2222);
        $display("back-to-back test done");
        // second reset mid-run: values return to their reset state
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        i_bwcr_host.rd(8'h24, rdv);
        check(rdv, 32'h0001_0001);
        foreach (rows[k]) begin
            if (k > 0 && k < 4) begin
                i_bwcr_host.rd(rows[k].ofs, rdv);
                check(rdv, 32'h0);
            end
        end
        probe(64'hF_FFFF, 2'b10);
        probe(64'h10_0000, 2'b00);
        $display("reset test done");
        // window edges: mem 1_1000_0000..1_1FFF_FFFF, io 1_3000..2_5FFF
        i_bwcr_host.wr(8'h24, 4'hF, 32'h1FF0_1000);
        i_bwcr_host.wr(8'h28, 4'hF, 32'h1);
        i_bwcr_host.wr(8'h2C, 4'hF, 32'h1);
        i_bwcr_host.wr(8'h30, 4'hF, 32'h0002_0001);
        io_base_low <= 4'h3;
        io_limit_low <= 4'h5;
        probe(64'h1_1000_0000, 2'b10);
        probe(64'h1_0FFF_FFFF, 2'b00);
        probe(64'h1_1FFF_FFFF, 2'b10);
        probe(64'h1_2000_0000, 2'b00);
        probe(64'h1_3000, 2'b01);
        probe(64'h1_2FFF, 2'b00);
        probe(64'h2_5FFF, 2'b01);
        probe(64'h2_6000, 2'b00);
        probe(64'h1_0001_3000, 2'b00);
        $display("window edge test done");
        // clock enable low freezes hits and ignores writes
        probe(64'h1_1000_0000, 2'b10);
        @(posedge clk);
        ce <= 1'b0;
        fwd_addr <= 64'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check({mem_hit, io_hit}, 2'b10);
        i_bwcr_host.wr(8'h28, 4'hF, 32'h5);
        @(posedge clk);
        ce <= 1'b1;
        i_bwcr_host.rd(8'h28, rdv);
        check(rdv, 32'h1);
        $display("clock enable test done");
        wrap_up();
    end
endmodule : bridge_window_config_regs_tb_top

// file: bench/bwcr_host.sv
// host model issuing configuration writes and reads on the primary side
module bwcr_host (
    // clock and returned data
    input wire logic clk,
    input wire logic [31:0] cfg_rdata,
    // configuration request
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_offset,
    output logic [3:0] cfg_byte_en,
    output logic [31:0] cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus at time zero
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_offset = 8'hFF;
        cfg_byte_en = 4'h0;
        cfg_wdata = 32'h0;
    end
    // one-cycle write; data scrambled after release so stale data never looks valid
    task automatic wr(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_offset <= ofs;
        cfg_byte_en <= be;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
        cfg_wdata <= ~d;
    endtask : wr
    // one-cycle read; registered data is settled by the falling edge
    task automatic rd(input logic [7:0] ofs, output logic [31:0] d);
        @(posedge clk);
        cfg_rd <= 1'b1;
        cfg_offset <= ofs;
        @(posedge clk);
        cfg_rd <= 1'b0;
        @(negedge clk);
        d = cfg_rdata;
    endtask : rd
    // write then read the same offset on the very next edge
    task automatic wr_rd(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] d,
                         output logic [31:0] q);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_offset <= ofs;
        cfg_byte_en <= be;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
        cfg_wdata <= ~d;
        cfg_rd <= 1'b1;
        @(posedge clk);
        cfg_rd <= 1'b0;
        @(negedge clk);
        q = cfg_rdata;
    endtask : wr_rd
endmodule : bwcr_host

// file: verilog/bwcr_decode.sv
// window compare, purely combinational
module bwcr_decode (
    // window and address bundle
    bwcr_win_if.dec win
);
    import bwcr_pkg::*;

    // inclusive range test on both ends
    function automatic logic bwcr_in_range(input logic [63:0] a, input logic [63:0] lo,
                                           input logic [63:0] hi);
        bwcr_in_range = (a >= lo) && (a <= hi);
    endfunction : bwcr_in_range

    // memory window uses the whole 64-bit address
    assign win.mem_in = bwcr_in_range(win.addr, win.mem_bottom, win.mem_top);
    // io space is only 32 bits wide, upper address must be zero
    assign win.io_in = bwcr_in_range(win.addr, {32'h0000_0000, win.io_bottom},
                                     {32'h0000_0000, win.io_top});
endmodule : bwcr_decode

// file: verilog/bwcr_pkg.sv
package bwcr_pkg;
    // configuration dword offsets
    localparam logic [7:0] BWCR_OFS_PREF_WIN = 8'h24;
    localparam logic [7:0] BWCR_OFS_PREF_BOT_HI = 8'h28;
    localparam logic [7:0] BWCR_OFS_PREF_TOP_HI = 8'h2C;
    localparam logic [7:0] BWCR_OFS_IO_HI = 8'h30;
    localparam logic [7:0] BWCR_OFS_CAP_PTR = 8'h34;
    // field positions inside the prefetch window word
    localparam int BWCR_PBOT_LSB = 4;
    localparam int BWCR_PTOP_LSB = 20;
    localparam int BWCR_PTOP_ADDR_LSB = 16;
    // field positions inside the io upper word
    localparam int BWCR_IOTOP_LSB = 16;
    // reset and fixed values
    localparam logic [3:0] BWCR_ADDR64_CODE = 4'h1;
    localparam logic [7:0] BWCR_CAP_PTR_VAL = 8'hDC;
    localparam logic [11:0] BWCR_PFIELD_RST = 12'h000;
    localparam logic [31:0] BWCR_HI_WORD_RST = 32'h0000_0000;
    localparam logic [15:0] BWCR_IO_HALF_RST = 16'h0000;
    // implied low address bits of the windows
    localparam logic [19:0] BWCR_MEM_LOW_BOT = 20'h00000;
    localparam logic [19:0] BWCR_MEM_LOW_TOP = 20'hFFFFF;
    localparam logic [11:0] BWCR_IO_LOW_BOT = 12'h000;
    localparam logic [11:0] BWCR_IO_LOW_TOP = 12'hFFF;
endpackage : bwcr_pkg

// file: verilog/bwcr_regs.sv
//Contract
//- prefetch bottom: 12 writable bits, low zero
//- prefetch top: 12 writable bits, low ones
//- prefetch window steers memory forwarding
//- upper 32 bits of bottom, reset zero
//- upper 32 bits of top, reset zero
//- io bottom upper half, reset zero
//- io top upper half, reset zero
//- capability pointer reads fixed DCh
//- io top low twelve bits ones
module bwcr_regs (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // configuration access from the primary side
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_offset,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    // lower io window bits from the io base/limit register
    input wire logic [3:0] io_base_low,
    input wire logic [3:0] io_limit_low,
    // forwarding decode
    input wire logic [63:0] fwd_addr,
    output logic mem_hit,
    output logic io_hit
);
    import bwcr_pkg::*;

    // reset release synchroniser
    logic rst_meta_reg;
    logic rst_sync_n;
    // writable fields
    logic [11:0] pref_bot_reg; // address bits 31:20 of bottom
    logic [11:0] pref_top_reg; // address bits 31:20 of top
    logic [31:0] pref_bot_hi_reg; // address bits 63:32 of bottom
    logic [31:0] pref_top_hi_reg; // address bits 63:32 of top
    logic [15:0] io_bot_hi_reg; // io bottom bits 31:16
    logic [15:0] io_top_hi_reg; // io top bits 31:16
    logic [31:0] rdata_next;
    logic [31:0] pref_word;
    logic [31:0] pref_merged; // 24h word after byte-lane merge
    logic [31:0] io_merged; // 30h word after byte-lane merge
    bwcr_win_if win ();

    // byte-lane merge for a write
    function automatic logic [31:0] bwcr_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        bwcr_merge = (new_v & m) | (old_v & ~m);
    endfunction : bwcr_merge

    // release reset through two flops, assert asynchronously
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n <= rst_meta_reg;
        end
    end

    // the shared word at 24h as software sees it
    assign pref_word = {pref_top_reg, BWCR_ADDR64_CODE, pref_bot_reg, BWCR_ADDR64_CODE};

    // merged words, sliced below; a function result cannot be part-selected directly
    assign pref_merged = bwcr_merge(pref_word, cfg_wdata, cfg_byte_en);
    assign io_merged = bwcr_merge({io_top_hi_reg, io_bot_hi_reg}, cfg_wdata, cfg_byte_en);

    // prefetch base and limit word, low nibbles never stored
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pref_bot_reg <= BWCR_PFIELD_RST;
            pref_top_reg <= BWCR_PFIELD_RST;
        end else if (ce && cfg_wr && cfg_offset == BWCR_OFS_PREF_WIN) begin
            // slices skip the read-only nibbles, so they stay at their code
            pref_bot_reg <= pref_merged[BWCR_PBOT_LSB +: 12];
            pref_top_reg <= pref_merged[BWCR_PTOP_LSB +: 12];
        end
    end

    // upper 32 bits of the prefetch bottom
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pref_bot_hi_reg <= BWCR_HI_WORD_RST;
        end else if (ce && cfg_wr && cfg_offset == BWCR_OFS_PREF_BOT_HI) begin
            pref_bot_hi_reg <= bwcr_merge(pref_bot_hi_reg, cfg_wdata, cfg_byte_en);
        end
    end

    // upper 32 bits of the prefetch top
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pref_top_hi_reg <= BWCR_HI_WORD_RST;
        end else if (ce && cfg_wr && cfg_offset == BWCR_OFS_PREF_TOP_HI) begin
            pref_top_hi_reg <= bwcr_merge(pref_top_hi_reg, cfg_wdata, cfg_byte_en);
        end
    end

    // io upper halves share one dword
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            io_bot_hi_reg <= BWCR_IO_HALF_RST;
            io_top_hi_reg <= BWCR_IO_HALF_RST;
        end else if (ce && cfg_wr && cfg_offset == BWCR_OFS_IO_HI) begin
            io_bot_hi_reg <= io_merged[15:0];
            io_top_hi_reg <= io_merged[BWCR_IOTOP_LSB +: 16];
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        case (cfg_offset)
            BWCR_OFS_PREF_WIN: rdata_next = pref_word;
            BWCR_OFS_PREF_BOT_HI: rdata_next = pref_bot_hi_reg;
            BWCR_OFS_PREF_TOP_HI: rdata_next = pref_top_hi_reg;
            BWCR_OFS_IO_HI: rdata_next = {io_top_hi_reg, io_bot_hi_reg};
            BWCR_OFS_CAP_PTR: rdata_next = {24'h000000, BWCR_CAP_PTR_VAL};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // read data registered, valid the cycle after cfg_rd
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg_rdata <= 32'h0000_0000;
        end else if (ce && cfg_rd) begin
            cfg_rdata <= rdata_next;
        end
    end

    // assemble full window addresses with implied low bits
    assign win.mem_bottom = {pref_bot_hi_reg, pref_bot_reg, BWCR_MEM_LOW_BOT};
    assign win.mem_top = {pref_top_hi_reg, pref_top_reg, BWCR_MEM_LOW_TOP};
    assign win.io_bottom = {io_bot_hi_reg, io_base_low, BWCR_IO_LOW_BOT};
    assign win.io_top = {io_top_hi_reg, io_limit_low, BWCR_IO_LOW_TOP};
    assign win.addr = fwd_addr;

    // the compare sits in its own module so it can be reused per port
    bwcr_decode u_decode (
        .win(win)
    );

    // hit flags registered; one cycle of latency is cheaper than a long compare path
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mem_hit <= 1'b0;
            io_hit <= 1'b0;
        end else if (ce) begin
            mem_hit <= win.mem_in;
            io_hit <= win.io_in;
        end
    end

    // capability pointer reads its fixed value
    cap_ptr_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (ce && cfg_rd && cfg_offset == BWCR_OFS_CAP_PTR) |=> cfg_rdata == 32'h0000_00DC)
        else $error("capability pointer read wrong");

    // read-only nibbles always report 64-bit code
    low_nibble_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (ce && cfg_rd && cfg_offset == BWCR_OFS_PREF_WIN)
        |=> (cfg_rdata[3:0] == 4'h1 && cfg_rdata[19:16] == 4'h1))
        else $error("prefetch low nibble not one");

    // full write to bottom high word is stored
    bot_hi_wr_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (ce && cfg_wr && cfg_offset == 8'h28 && cfg_byte_en == 4'hF)
        |=> pref_bot_hi_reg == $past(cfg_wdata))
        else $error("bottom high word not written");

    // top high word readback after full write
    top_hi_rd_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (ce && cfg_wr && cfg_offset == 8'h2C && cfg_byte_en == 4'hF)
        ##1 (ce && cfg_rd && cfg_offset == 8'h2C && !cfg_wr)
        |=> cfg_rdata == $past(cfg_wdata, 2))
        else $error("top high word readback wrong");

    // io halves land in the right lanes
    io_half_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (ce && cfg_wr && cfg_offset == 8'h30 && cfg_byte_en == 4'h3)
        |=> (io_bot_hi_reg == $past(cfg_wdata[15:0])
             && io_top_hi_reg == $past(io_top_hi_reg)))
        else $error("io bottom half write wrong");

    // io top upper half write
    io_top_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (ce && cfg_wr && cfg_offset == 8'h30 && cfg_byte_en == 4'hC)
        |=> io_top_hi_reg == $past(cfg_wdata[31:16]))
        else $error("io top half write wrong");

    // implied bits of the memory window and of the io top
    win_low_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        win.mem_bottom[19:0] == 20'h00000 && win.mem_top[19:0] == 20'hFFFFF
        && win.io_top[11:0] == 12'hFFF && win.io_top[15:12] == io_limit_low)
        else $error("implied window bits wrong");

    // memory hit follows the inclusive compare one cycle later
    // the edge that releases reset still holds the flags cleared, so it starts no attempt
    mem_hit_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (ce && rst_sync_n) |=> mem_hit == ($past(fwd_addr) >= $past(win.mem_bottom)
                           && $past(fwd_addr) <= $past(win.mem_top)))
        else $error("memory hit mismatch");

    // a frozen clock enable holds the hit flags
    hit_hold_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        !ce |=> ($stable(mem_hit) && $stable(io_hit)))
        else $error("hit changed while disabled");
endmodule : bwcr_regs

// file: verilog/bwcr_win_if.sv
// assembled windows travel to the decoder, hit flags come back
interface bwcr_win_if;
    logic [63:0] mem_bottom; // full 64-bit prefetch bottom
    logic [63:0] mem_top; // full 64-bit prefetch top
    logic [31:0] io_bottom; // full 32-bit io bottom
    logic [31:0] io_top; // full 32-bit io top
    logic [63:0] addr; // address under test
    logic mem_in; // address inside prefetch window
    logic io_in; // address inside io window
    modport regs (output mem_bottom, output mem_top, output io_bottom, output io_top,
                  output addr, input mem_in, input io_in);
    modport dec (input mem_bottom, input mem_top, input io_bottom, input io_top,
                 input addr, output mem_in, output io_in);
endinterface : bwcr_win_if
